// [dv/board_straps.sv]
/*
 board side: strap resistors, boot jumper and button levels, power good.
 assumes i_set holds the wanted levels by the package strap positions.
*/
`timescale 1ns/1ps
module board_straps
    import strap_cfg_pkg::*;
(
    // wanted levels
    input wire logic [16:0] i_set,
    input wire logic i_pg,
    // strap pins
    output logic [3:0] o_mgr,
    output logic o_scan,
    output logic o_dbg,
    output logic o_por,
    output logic o_pbyp,
    output logic o_plloff,
    output logic o_pllbyp,
    output logic [2:0] o_spare,
    output logic o_boot1,
    output logic o_wlong,
    output logic o_usb_n,
    output logic o_card_n,
    output logic o_pg
);
    assign o_mgr = i_set[3:0];
    assign o_scan = i_set[POS_SCAN_TEST];
    assign o_dbg = i_set[POS_DEBUG_PORT];
    assign o_por = i_set[POS_POR_GEN_ON];
    assign o_pbyp = i_set[POS_PROC_RST_BYP];
    // board never powers plls down unless they are bypassed too
    assign o_plloff = i_set[POS_PLL_POWER_OFF] & i_set[POS_PLL_BYPASS];
    assign o_pllbyp = i_set[POS_PLL_BYPASS];
    assign o_spare = i_set[12:10];
    assign o_boot1 = i_set[POS_BOOT_BIT1];
    assign o_wlong = i_set[POS_WAIT_LONG];
    assign o_usb_n = i_set[POS_USB_BOOT_N];
    assign o_card_n = i_set[POS_CARD_BOOT_N];
    assign o_pg = i_pg;
endmodule

// [dv/strap_cfg_props.sv]
/*
 checker for the strap boot and reset configuration block.
 assumes straps stay static from reset entry until the sample is taken.
*/
`timescale 1ns/1ps
module strap_cfg_props
    import strap_cfg_pkg::*;
#(
    parameter int SHORT_WAIT_CYCLES = RESET_WAIT_SHORT_CYCLES,
    parameter int LONG_WAIT_CYCLES = RESET_WAIT_LONG_CYCLES
)
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // straps and power good
    input wire logic [3:0] i_manager_config_bits,
    input wire logic i_scan_test_select,
    input wire logic i_debug_port_select,
    input wire logic i_power_on_reset_gen_on,
    input wire logic i_processor_reset_bypass,
    input wire logic i_pll_power_off,
    input wire logic i_pll_bypass_all,
    input wire logic i_boot_source_bit1,
    input wire logic i_reset_wait_long,
    input wire logic i_usb_boot_request_n,
    input wire logic i_card_boot_request_n,
    input wire logic i_core_power_good,
    // outputs watched
    input wire logic o_chip_reset_out_n,
    input wire logic o_config_valid,
    input wire logic o_debug_jtag_on,
    input wire logic o_scan_test_on,
    input wire logic o_debug_port_factory,
    input wire logic o_power_on_reset_gen_on,
    input wire logic o_processor_reset_bypass,
    input wire logic o_pll_bypass_all,
    input wire logic o_pll_power_off,
    input wire logic [1:0] o_boot_source
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    // mode and wait length caught at the sample, live pins may move later
    logic [1:0] lat;
    logic vq;
    logic [WAIT_COUNT_W-1:0] wcnt;
    wire [WAIT_COUNT_W-1:0] wlo = lat[0] ? WAIT_COUNT_W'(LONG_WAIT_CYCLES) : WAIT_COUNT_W'(SHORT_WAIT_CYCLES);
    wire [1:0] exp_boot = !i_usb_boot_request_n ? 2'h2 : !i_card_boot_request_n ? 2'h3 :
        i_boot_source_bit1 ? 2'h0 : 2'h1;
    always_ff @(posedge i_clock or negedge i_rstn)
        if (!i_rstn)
        begin
            lat <= 2'h0;
            vq <= 1'b0;
            wcnt <= '0;
        end
        else
        begin
            vq <= o_config_valid;
            if (o_config_valid && !vq)
                lat <= {i_manager_config_bits[0], i_reset_wait_long};
            if (o_config_valid && wcnt != '1)
                wcnt <= wcnt + WAIT_COUNT_W'(1);
        end

    cfg_hold_a: assert property (o_config_valid && $past(o_config_valid) |-> $stable({o_boot_source,
        o_debug_jtag_on, o_scan_test_on, o_debug_port_factory, o_power_on_reset_gen_on,
        o_processor_reset_bypass, o_pll_bypass_all, o_pll_power_off})) else $error("config moved after sample");
    early_rst_a: assert property (!o_config_valid |-> !o_chip_reset_out_n)
        else $error("chip reset released before sample");
    jtag_excl_a: assert property (o_config_valid |-> o_debug_jtag_on != o_scan_test_on)
        else $error("debug and scan both or neither");
    dbg_port_a: assert property ($rose(o_config_valid) |-> o_scan_test_on == $past(i_scan_test_select, 3)
        && o_debug_port_factory == $past(i_debug_port_select, 3)) else $error("debug select wrong");
    por_byp_a: assert property ($rose(o_config_valid) |->
        o_power_on_reset_gen_on == $past(i_power_on_reset_gen_on, 3)
        && o_processor_reset_bypass == $past(i_processor_reset_bypass, 3)) else $error("por or bypass wrong");
    pll_cfg_a: assert property ($rose(o_config_valid) |-> {o_pll_bypass_all, o_pll_power_off} ==
        $past({i_pll_bypass_all, i_pll_power_off}, 3)) else $error("pll config wrong");
    boot_pick_a: assert property ($rose(o_config_valid) |-> o_boot_source == $past(exp_boot, 3))
        else $error("boot source wrong");
    wait_min_a: assert property ($rose(o_chip_reset_out_n) |-> wcnt >= wlo)
        else $error("chip reset released too early");
    wait_max_a: assert property (!lat[1] && wcnt == wlo + WAIT_COUNT_W'(4) |-> o_chip_reset_out_n)
        else $error("chip reset not released after wait");
    pg_gate_a: assert property ($rose(o_chip_reset_out_n) && lat[1] |-> $past(i_core_power_good, 2))
        else $error("chip reset released without power good");

    cover property ($rose(o_chip_reset_out_n) && lat[1]);
    cover property ($rose(o_config_valid) ##1 o_boot_source == 2'h2);
    cover property ($rose(o_config_valid) ##1 o_scan_test_on);
endmodule

// [dv/test_strap_boot_reset_config.sv]
/*
 testbench: strap rows, reset wait timing, power good gating, register reads.
 assumes short wait counts of 20 and 50 cycles on a 50 MHz clock.
*/
`timescale 1ns/1ps
module test_strap_boot_reset_config
    import strap_cfg_pkg::*;
;
    typedef struct packed {logic [16:0] s; logic [1:0] b; logic [6:0] c;} row_t;
    row_t rows [8] = '{'{17'h1a040, 2'h0, 7'h48}, '{17'h18040, 2'h1, 7'h48}, '{17'h12040, 2'h2, 7'h48},
        '{17'h02040, 2'h2, 7'h48}, '{17'h0a040, 2'h3, 7'h48}, '{17'h08040, 2'h3, 7'h48},
        '{17'h1ffbe, 2'h0, 7'h37}, '{17'h1a240, 2'h0, 7'h4a}};
    logic i_clock = 1'b0;
    logic i_rstn = 1'b0;
    logic [16:0] s_set = 17'h1a040;
    logic pg = 1'b0;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] mgr;
    logic [2:0] spare;
    logic scan, dbg, por, pbyp, plloff, pllbyp, boot1, wlong, usb_n, card_n, pgo;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest, o_chip_reset_out_n, o_config_valid, jtag_on, scan_on, fact, por_on, pbyp_on;
    logic pllbyp_on, plloff_on;
    logic [1:0] o_boot_source;
    wire [6:0] cfg = {jtag_on, scan_on, fact, por_on, pbyp_on, pllbyp_on, plloff_on};
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;

    always #10 i_clock = ~i_clock;

    board_straps u_board (.i_set(s_set), .i_pg(pg), .o_mgr(mgr), .o_scan(scan), .o_dbg(dbg), .o_por(por),
        .o_pbyp(pbyp), .o_plloff(plloff), .o_pllbyp(pllbyp), .o_spare(spare), .o_boot1(boot1), .o_wlong(wlong),
        .o_usb_n(usb_n), .o_card_n(card_n), .o_pg(pgo));
    // short counts keep each row to a few dozen cycles
    strap_boot_reset_config #(.SHORT_WAIT_CYCLES(20), .LONG_WAIT_CYCLES(50)) dut (.i_clock(i_clock),
        .i_rstn(i_rstn), .i_manager_config_bits(mgr), .i_scan_test_select(scan), .i_debug_port_select(dbg),
        .i_power_on_reset_gen_on(por), .i_processor_reset_bypass(pbyp), .i_pll_power_off(plloff),
        .i_pll_bypass_all(pllbyp), .i_chip_spare_bits(spare), .i_boot_source_bit1(boot1),
        .i_reset_wait_long(wlong), .i_usb_boot_request_n(usb_n), .i_card_boot_request_n(card_n),
        .i_core_power_good(pgo), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hf), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .o_chip_reset_out_n(o_chip_reset_out_n), .o_config_valid(o_config_valid), .o_debug_jtag_on(jtag_on),
        .o_scan_test_on(scan_on), .o_debug_port_factory(fact), .o_power_on_reset_gen_on(por_on),
        .o_processor_reset_bypass(pbyp_on), .o_pll_bypass_all(pllbyp_on), .o_pll_power_off(plloff_on),
        .o_boot_source(o_boot_source));

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // holds the request until waitrequest is seen low, then lets an edge pass
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int k;
        k = 0;
        addr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        @(posedge i_clock);
        while (o_avs_waitrequest !== 1'b0 && k < 50)
        begin
            @(posedge i_clock);
            k++;
        end
        chk("waitrequest", 32'h0, {31'h0, o_avs_waitrequest});
        r = o_avs_readdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge i_clock);
    endtask

    task automatic rst(input logic [16:0] s, input logic p);
        int k;
        k = 0;
        i_rstn <= 1'b0;
        s_set <= s;
        pg <= p;
        repeat (6) @(posedge i_clock);
        chk("reset out", 32'h0, {31'h0, o_chip_reset_out_n});
        chk("valid", 32'h0, {31'h0, o_config_valid});
        i_rstn <= 1'b1;
        while (o_config_valid !== 1'b1 && k < 20)
        begin
            @(posedge i_clock);
            k++;
        end
        chk("latched", 32'h1, {31'h0, o_config_valid});
    endtask

    always @(posedge i_clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            end_sim();
        end
    end

    initial
    begin
        logic [31:0] r;
        int k;
        int lo;
        @(posedge i_clock);
        foreach (rows[i])
        begin
            rst(rows[i].s, 1'b0);
            chk("boot", {30'h0, rows[i].b}, {30'h0, o_boot_source});
            chk("config", {25'h0, rows[i].c}, {25'h0, cfg});
            k = 0;
            lo = rows[i].s[14] ? 50 : 20;
            while (o_chip_reset_out_n !== 1'b1 && k < 200)
            begin
                @(posedge i_clock);
                k++;
            end
            chk("wait", 32'h1, {31'h0, k >= lo && k <= lo + 4});
            bus(1'b0, OFS_STRAPS, 32'h0, r);
            chk("straps reg", {15'h0, rows[i].s}, {15'h0, r[16:0]});
            s_set <= ~rows[i].s;
            repeat (4) @(posedge i_clock);
            chk("held", {23'h0, rows[i].b, rows[i].c}, {23'h0, o_boot_source, cfg});
        end
        bus(1'b1, 4'h2, 32'hffffffff, r);
        bus(1'b0, 4'h2, 32'h0, r);
        chk("unmapped", 32'h0, r);
        bus(1'b1, OFS_CONTROL, 32'h1, r);
        @(posedge i_clock);
        chk("hold", 32'h0, {31'h0, o_chip_reset_out_n});
        bus(1'b1, OFS_CONTROL, 32'h0, r);
        repeat (2) @(posedge i_clock);
        chk("unhold", 32'h1, {31'h0, o_chip_reset_out_n});
        rst(17'h1a041, 1'b0);
        repeat (80) @(posedge i_clock);
        chk("pg gate", 32'h0, {31'h0, o_chip_reset_out_n});
        pg <= 1'b1;
        repeat (8) @(posedge i_clock);
        chk("pg release", 32'h1, {31'h0, o_chip_reset_out_n});
        bus(1'b0, OFS_STATUS, 32'h0, r);
        chk("status", 32'h0000000f, r);
        end_sim();
    end
endmodule

bind strap_boot_reset_config strap_cfg_props #(.SHORT_WAIT_CYCLES(SHORT_WAIT_CYCLES),
    .LONG_WAIT_CYCLES(LONG_WAIT_CYCLES)) u_props (.i_clock, .i_rstn, .i_manager_config_bits, .i_scan_test_select,
    .i_debug_port_select, .i_power_on_reset_gen_on, .i_processor_reset_bypass, .i_pll_power_off, .i_pll_bypass_all,
    .i_boot_source_bit1, .i_reset_wait_long, .i_usb_boot_request_n, .i_card_boot_request_n, .i_core_power_good,
    .o_chip_reset_out_n, .o_config_valid, .o_debug_jtag_on, .o_scan_test_on, .o_debug_port_factory,
    .o_power_on_reset_gen_on, .o_processor_reset_bypass, .o_pll_bypass_all, .o_pll_power_off, .o_boot_source);

// [hdl/reset_wait_counter.sv]
/*
 down counter for the chip reset wait. load sets the count, expired is high
 once it has run down to zero. assumes load and run are never both high.
*/
`timescale 1ns/1ps
module reset_wait_counter
    import strap_cfg_pkg::*;
#(
    parameter int COUNT_W = WAIT_COUNT_W
)
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // control
    input wire logic i_load,
    input wire logic [COUNT_W-1:0] i_load_value,
    input wire logic i_run,
    // status
    output logic o_expired,
    output logic [COUNT_W-1:0] o_remaining
);

    typedef struct packed {
        logic [COUNT_W-1:0] count;
        logic armed;
    } counter_state_t;

    counter_state_t state;
    counter_state_t next_state;

    always_comb
    begin
        next_state = state;
        if (i_load)
        begin
            next_state.count = i_load_value;
            next_state.armed = 1'b1;
        end
        else if (i_run && state.count != '0)
        begin
            next_state.count = state.count - COUNT_W'(1);
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // never expired before the first load, so reset cannot leak out early
    assign o_expired = state.armed && state.count == '0;
    assign o_remaining = state.count;

endmodule

// [hdl/strap_boot_reset_config.sv]
/*
 strap-sampled boot and reset configuration. samples board straps after system
 reset release, drives the chip reset release sequence, the debug, pll and
 reset-bypass configuration and the boot source, and shows all of it to
 software over an avalon-mm slave with waitrequest.
 assumes i_rstn is the system reset, straps are static levels from the board.
*/
// Chosen here: the Avalon-MM register port and the register offsets.
// Contract
// - release mode 0: release chip reset when wait counter expires, ignore power good
// - release mode 1: release chip reset only after counter expiry and power good
// - test select 0 enables processor debug jtag; 1 enables scan tests
// - debug port select 0 routes to processor debug; 1 is factory only
// - power-on-reset strap 1 enables the on-chip generator; 0 bypasses it
// - processor reset bypass 0 keeps partition reset logic; 1 bypasses it
// - pll bypass 1 bypasses system, memory and processor plls
// - pll power-off 1 powers down those plls; 0 keeps them powered
// - boot bit 1 selects emmc when 1, spi flash when 0
// - reset wait strap selects 2 ms when 0, 20 ms when 1
// - usb boot request low at reset release selects usb boot
// - card boot request low at reset release selects sd card boot
// - six spare straps are captured for software, no hardware effect
`timescale 1ns/1ps
module strap_boot_reset_config
    import strap_cfg_pkg::*;
#(
    parameter int SHORT_WAIT_CYCLES = RESET_WAIT_SHORT_CYCLES,
    parameter int LONG_WAIT_CYCLES = RESET_WAIT_LONG_CYCLES
)
(
    // clock and system reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // manager straps: bit 0 release mode, bits 3:1 spare
    input wire logic [3:0] i_manager_config_bits,
    input wire logic i_scan_test_select,
    input wire logic i_debug_port_select,
    input wire logic i_power_on_reset_gen_on,
    // chip straps
    input wire logic i_processor_reset_bypass,
    input wire logic i_pll_power_off,
    input wire logic i_pll_bypass_all,
    input wire logic [SPARE_W-1:0] i_chip_spare_bits,
    input wire logic i_boot_source_bit1,
    input wire logic i_reset_wait_long,
    // board boot requests, active low
    input wire logic i_usb_boot_request_n,
    input wire logic i_card_boot_request_n,
    // power good from the board
    input wire logic i_core_power_good,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // chip reset and configuration
    output logic o_chip_reset_out_n,
    output logic o_config_valid,
    output logic o_debug_jtag_on,
    output logic o_scan_test_on,
    output logic o_debug_port_factory,
    output logic o_power_on_reset_gen_on,
    output logic o_processor_reset_bypass,
    output logic o_pll_bypass_all,
    output logic o_pll_power_off,
    output logic [1:0] o_boot_source
);

    typedef struct packed {
        seq_state_t seq;
        logic [1:0] settle;
        logic [STRAP_W-1:0] straps;
        logic hold_reset;
        logic ack;
        logic [31:0] rdata;
        logic reset_out_n;
    } top_state_t;

    top_state_t state;
    top_state_t next_state;

    logic [STRAP_W-1:0] pins;
    logic [STRAP_W-1:0] synced;
    logic load_wait;
    logic run_wait;
    logic wait_expired;
    logic [WAIT_COUNT_W-1:0] wait_remaining;
    logic [WAIT_COUNT_W-1:0] wait_value;
    logic bus_request;
    logic power_good;
    logic release_ok;

    // boot source decode, shared by the outputs and the status register
    function automatic boot_source_t pick_boot(input logic [STRAP_W-1:0] s);
        boot_source_t b;
        b = BOOT_EMMC;
        if (!s[POS_USB_BOOT_N])
        begin
            b = BOOT_USB;
        end
        else if (!s[POS_CARD_BOOT_N])
        begin
            b = BOOT_CARD;
        end
        else if (s[POS_BOOT_BIT1])
        begin
            b = BOOT_EMMC;
        end
        else
        begin
            b = BOOT_SPI;
        end
        return b;
    endfunction

    // pll power-off without bypass would stop the clocks outright
    function automatic logic pll_conflict(input logic [STRAP_W-1:0] s);
        return s[POS_PLL_POWER_OFF] && !s[POS_PLL_BYPASS];
    endfunction

    assign pins = {
        i_core_power_good,
        i_card_boot_request_n,
        i_usb_boot_request_n,
        i_reset_wait_long,
        i_boot_source_bit1,
        i_chip_spare_bits,
        i_pll_bypass_all,
        i_pll_power_off,
        i_processor_reset_bypass,
        i_power_on_reset_gen_on,
        i_debug_port_select,
        i_scan_test_select,
        i_manager_config_bits
    };

    // board levels cross into the clock domain before anything reads them
    strap_sync #(
        .WIDTH(STRAP_W),
        .INIT(STRAP_RESET)
    ) u_sync (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_level(pins),
        .o_level(synced)
    );

    reset_wait_counter #(
        .COUNT_W(WAIT_COUNT_W)
    ) u_wait (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_load(load_wait),
        .i_load_value(wait_value),
        .i_run(run_wait),
        .o_expired(wait_expired),
        .o_remaining(wait_remaining)
    );

    // wait length from the live strap: latching and loading share one cycle
    assign wait_value = synced[POS_WAIT_LONG] ? WAIT_COUNT_W'(LONG_WAIT_CYCLES)
        : WAIT_COUNT_W'(SHORT_WAIT_CYCLES);
    assign load_wait = state.seq == SEQ_SETTLE && state.settle == SETTLE_CYCLES;
    assign run_wait = state.seq == SEQ_WAIT;
    assign power_good = synced[POS_POWER_GOOD];
    assign bus_request = i_avs_read || i_avs_write;

    // release decision: mode 0 ignores power good, mode 1 needs it
    always_comb
    begin
        if (state.straps[POS_RELEASE_MODE])
        begin
            release_ok = wait_expired && power_good;
        end
        else
        begin
            release_ok = wait_expired;
        end
    end

    always_comb
    begin
        next_state = state;
        next_state.ack = bus_request && !state.ack;

        unique case (state.seq)
            SEQ_SETTLE:
            begin
                if (state.settle == SETTLE_CYCLES)
                begin
                    // one capture only; after it only the power good pin is still looked at
                    next_state.straps = synced;
                    next_state.seq = SEQ_WAIT;
                end
                else
                begin
                    next_state.settle = state.settle + 2'h1;
                end
            end
            SEQ_WAIT:
            begin
                if (wait_expired)
                begin
                    next_state.seq = state.straps[POS_RELEASE_MODE] ? SEQ_POWER : SEQ_RUN;
                end
            end
            SEQ_POWER:
            begin
                if (release_ok)
                begin
                    next_state.seq = SEQ_RUN;
                end
            end
            SEQ_RUN:
            begin
                next_state.seq = SEQ_RUN;
            end
        endcase

        // chip reset: released once the sequence reaches run, unless software holds it or power good drops in mode 1
        next_state.reset_out_n = next_state.seq == SEQ_RUN && release_ok && !next_state.hold_reset;

        // register read data is prepared in the first cycle of a read
        if (i_avs_read && !state.ack)
        begin
            next_state.rdata = '0;
            unique case (i_avs_address)
                OFS_STRAPS:
                begin
                    next_state.rdata = 32'(state.straps);
                end
                OFS_STATUS:
                begin
                    next_state.rdata[ST_STATE_LSB +: 2] = state.seq;
                    next_state.rdata[ST_RELEASED] = state.reset_out_n;
                    next_state.rdata[ST_POWER_GOOD] = power_good;
                    next_state.rdata[ST_PLL_CONFLICT] = pll_conflict(state.straps);
                    next_state.rdata[ST_BOOT_LSB +: 2] = pick_boot(state.straps);
                    next_state.rdata[ST_FACTORY_PORT] = state.straps[POS_DEBUG_PORT];
                end
                OFS_CONTROL:
                begin
                    next_state.rdata[CTL_HOLD_RESET] = state.hold_reset;
                end
                OFS_REMAINING:
                begin
                    next_state.rdata = 32'(wait_remaining);
                end
                default:
                begin
                    next_state.rdata = '0;
                end
            endcase
        end

        // writes take effect at the edge where waitrequest is low
        if (i_avs_write && state.ack && i_avs_address == OFS_CONTROL && i_avs_byteenable[0])
        begin
            next_state.hold_reset = i_avs_writedata[CTL_HOLD_RESET];
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state.seq <= SEQ_SETTLE;
            state.settle <= '0;
            state.straps <= STRAP_RESET;
            state.hold_reset <= CONTROL_RESET;
            state.ack <= 1'b0;
            state.rdata <= '0;
            state.reset_out_n <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // one wait state per access, answer on the second edge
    assign o_avs_waitrequest = bus_request && !state.ack;
    assign o_avs_readdata = state.rdata;

    assign o_chip_reset_out_n = state.reset_out_n;
    assign o_config_valid = state.seq != SEQ_SETTLE;
    assign o_debug_jtag_on = !state.straps[POS_SCAN_TEST];
    assign o_scan_test_on = state.straps[POS_SCAN_TEST];
    // factory path is only exposed, never chosen by this block on its own
    assign o_debug_port_factory = state.straps[POS_DEBUG_PORT];
    assign o_power_on_reset_gen_on = state.straps[POS_POR_GEN_ON];
    assign o_processor_reset_bypass = state.straps[POS_PROC_RST_BYP];
    assign o_pll_bypass_all = state.straps[POS_PLL_BYPASS];
    assign o_pll_power_off = state.straps[POS_PLL_POWER_OFF];
    assign o_boot_source = pick_boot(state.straps);

endmodule

// [hdl/strap_cfg_pkg.sv]
/*
 strap configuration package: strap bit positions, pull defaults, reset wait
 times and cycle counts, register offsets and field layouts, state types.
 assumes a 50 MHz system clock.
*/
package strap_cfg_pkg;

    // clock and reset wait times
    localparam longint CLOCK_HZ = 50000000;
    localparam longint RESET_WAIT_SHORT_MS = 2;
    localparam longint RESET_WAIT_LONG_MS = 20;
    localparam int RESET_WAIT_SHORT_CYCLES = int'((RESET_WAIT_SHORT_MS * CLOCK_HZ + 999) / 1000);
    localparam int RESET_WAIT_LONG_CYCLES = int'((RESET_WAIT_LONG_MS * CLOCK_HZ + 999) / 1000);
    localparam int WAIT_COUNT_W = 24;

    // strap vector bit positions
    localparam int STRAP_W = 18;
    localparam int POS_RELEASE_MODE = 0;
    localparam int POS_MGR_SPARE = 1;
    localparam int POS_SCAN_TEST = 4;
    localparam int POS_DEBUG_PORT = 5;
    localparam int POS_POR_GEN_ON = 6;
    localparam int POS_PROC_RST_BYP = 7;
    localparam int POS_PLL_POWER_OFF = 8;
    localparam int POS_PLL_BYPASS = 9;
    localparam int POS_CHIP_SPARE = 10;
    localparam int POS_BOOT_BIT1 = 13;
    localparam int POS_WAIT_LONG = 14;
    localparam int POS_USB_BOOT_N = 15;
    localparam int POS_CARD_BOOT_N = 16;
    localparam int POS_POWER_GOOD = 17;
    localparam int SPARE_W = 3;

    // pull defaults: power-on-reset enable, boot bit 1, usb and card requests pulled up
    localparam logic [STRAP_W-1:0] STRAP_RESET = 18'h1a040;

    // clocks the strap sample waits after reset release, covering the synchroniser
    localparam logic [1:0] SETTLE_CYCLES = 2'h2;

    // register byte offsets
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_STRAPS = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_REMAINING = 4'hc;

    // status register fields
    localparam int ST_STATE_LSB = 0;
    localparam int ST_RELEASED = 2;
    localparam int ST_POWER_GOOD = 3;
    localparam int ST_PLL_CONFLICT = 4;
    localparam int ST_BOOT_LSB = 5;
    localparam int ST_FACTORY_PORT = 7;

    // control register fields
    localparam int CTL_HOLD_RESET = 0;
    localparam logic CONTROL_RESET = 1'b0;

    typedef enum logic [1:0] {BOOT_EMMC, BOOT_SPI, BOOT_USB, BOOT_CARD} boot_source_t;
    typedef enum logic [1:0] {SEQ_SETTLE, SEQ_WAIT, SEQ_POWER, SEQ_RUN} seq_state_t;

endpackage

// [hdl/strap_sync.sv]
/*
 two-stage synchroniser for a vector of slow board levels.
 assumes each bit is a quasi-static level; no bus coherency across bits.
*/
`timescale 1ns/1ps
module strap_sync
    import strap_cfg_pkg::*;
#(
    parameter int WIDTH = STRAP_W,
    parameter logic [WIDTH-1:0] INIT = '0
)
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // levels
    input wire logic [WIDTH-1:0] i_level,
    output logic [WIDTH-1:0] o_level
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    always_comb
    begin
        next_state.first = i_level;
        next_state.second = state.first;
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state <= {INIT, INIT};
        end
        else
        begin
            state <= next_state;
        end
    end

    assign o_level = state.second;

endmodule
